/* rtl/ubd_pkg.sv */
// Shared constants and types for the descriptor status engine
package ubd_pkg;

    // ==================================================================
    // Descriptor table layout
    // ==================================================================
    localparam logic [10:0] BD_BASE_ADDR   = 11'h400;
    localparam logic [1:0]  BD_OFS_STATUS  = 2'h0;
    localparam logic [1:0]  BD_OFS_COUNT   = 2'h1;
    localparam logic [1:0]  BD_OFS_ADR_LO  = 2'h2;
    localparam logic [1:0]  BD_OFS_ADR_HI  = 2'h3;
    localparam int          BD_IDX_W       = 6;
    localparam int          CNT_W          = 10;

    // ==================================================================
    // Status byte field positions
    // ==================================================================
    localparam int OWNER_BIT      = 7;
    localparam int TOGGLE_BIT     = 6;
    localparam int TOG_CHECK_BIT  = 3;
    localparam int STALL_EN_BIT   = 2;
    localparam int PID_LSB        = 2;
    localparam int CNT_HI_LSB     = 0;

    // ==================================================================
    // Token PIDs, last fetch step and default FIFO depth
    // ==================================================================
    localparam logic [3:0] PID_OUT   = 4'h1;
    localparam logic [3:0] PID_IN    = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hd;
    localparam logic [2:0] FETCH_LAST = 3'h4;
    localparam int         FIFO_DEPTH = 32;

    // ==================================================================
    // Types
    // ==================================================================
    typedef enum logic [1:0] {UBD_HS_ACK, UBD_HS_NAK, UBD_HS_STALL} ubd_hs_e;

    typedef struct packed {
        logic [3:0]          pid;
        logic [BD_IDX_W-1:0] bd;
    } ubd_token_s;

    typedef struct packed {
        logic       err;
        logic       nodata;
        logic       toggle;
        logic       last;
        logic [7:0] data;
    } ubd_rx_word_s;

    typedef struct packed {
        logic [BD_IDX_W-1:0] bd;
        logic [3:0]          pid;
        logic [CNT_W-1:0]    count;
    } ubd_done_s;

endpackage : ubd_pkg

/* rtl/ubd_engine.sv */
// Serial engine descriptor handler with its receive FIFO
`timescale 1ns/100ps
`default_nettype none

// ======================================================================
// Receive FIFO
// ======================================================================
module ubd_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } ubd_fifo_s;
    ubd_fifo_s fifo_reg;
    ubd_fifo_s fifo_next;
    logic      full;
    logic      empty;
    // Extra pointer bit tells full from empty
    assign empty     = fifo_reg.wr_ptr == fifo_reg.rd_ptr;
    assign full      = (fifo_reg.wr_ptr[AW] != fifo_reg.rd_ptr[AW])
                    && (fifo_reg.wr_ptr[AW-1:0] == fifo_reg.rd_ptr[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = fifo_reg.mem[fifo_reg.rd_ptr[AW-1:0]];
    // Push and pop
    always_comb begin
        fifo_next = fifo_reg;
        if (in_valid && !full) begin
            fifo_next.mem[fifo_reg.wr_ptr[AW-1:0]] = in_data;
            fifo_next.wr_ptr = fifo_reg.wr_ptr + 1'b1;
        end
        if (out_ready && !empty) begin
            fifo_next.rd_ptr = fifo_reg.rd_ptr + 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end
endmodule : ubd_fifo

// ======================================================================
// Descriptor engine
// ======================================================================
module ubd_engine
    import ubd_pkg::*;
#(
    parameter int RX_DEPTH = FIFO_DEPTH
) (
    input  wire logic                core_clk,
    input  wire logic                srst,
    input  wire logic                keep_ownership,
    input  wire logic                token_valid,
    input  wire ubd_pkg::ubd_token_s token,
    output logic                     token_ready,
    input  wire logic                rx_valid,
    input  wire ubd_pkg::ubd_rx_word_s rx_word,
    output logic                     rx_ready,
    output logic                     tx_valid,
    output logic [7:0]               tx_data,
    output logic                     tx_last,
    output logic                     tx_zero_len,
    input  wire logic                tx_ready,
    output logic                     hs_valid,
    output ubd_pkg::ubd_hs_e         hs_code,
    output logic                     ram_rd_en,
    output logic                     ram_wr_en,
    output logic [10:0]              ram_addr,
    output logic [7:0]               ram_wdata,
    input  wire logic [7:0]          ram_rdata,
    output logic                     endpoint_stall_set,
    output logic [5:0]               endpoint_stall_bd,
    output logic                     stall_irq,
    output logic                     transfer_done_flag,
    output ubd_pkg::ubd_done_s       transfer_status
);
    import ubd_pkg::*;
    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_DECIDE, S_TX_RD, S_TX_WAIT, S_TX_CAP, S_TX_SEND,
        S_RX, S_WB_CNT, S_WB_STAT, S_FINISH
    } ubd_state_e;
    typedef struct packed {
        ubd_state_e          st;
        logic [2:0]          step;
        logic [3:0]          pid;
        logic [BD_IDX_W-1:0] bd;
        logic [7:0]          stat;
        logic [7:0]          cnt_lo;
        logic [15:0]         adr;
        logic [CNT_W-1:0]    idx;
        logic                over;
        logic                tog_bad;
        logic                err;
        logic                tx_valid;
        logic [7:0]          tx_data;
        logic                tx_last;
        logic                tx_zero;
        logic                hs_valid;
        ubd_hs_e             hs_code;
        logic                ram_rd;
        logic                ram_wr;
        logic [10:0]         ram_addr;
        logic [7:0]          ram_wdata;
        logic                stall_set;
        logic                done;
        ubd_done_s           status;
    } ubd_eng_s;
    ubd_eng_s       eng_reg;
    ubd_eng_s       eng_next;
    ubd_rx_word_s   fifo_word;
    logic           fifo_valid;
    logic           fifo_pop;
    logic [10:0]    bd_addr;
    logic [CNT_W-1:0] max_cnt;
    logic           tog_check;
    logic           stall_en;
    // Received data is buffered so link bytes keep flowing during RAM writes
    ubd_fifo #(
        .WIDTH ($bits(ubd_rx_word_s)),
        .DEPTH (RX_DEPTH)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );
    // Decoded descriptor fields
    assign bd_addr   = BD_BASE_ADDR + {3'h0, eng_reg.bd, 2'h0};
    assign max_cnt   = {eng_reg.stat[CNT_HI_LSB+1:CNT_HI_LSB], eng_reg.cnt_lo};
    assign tog_check = eng_reg.stat[TOG_CHECK_BIT];
    assign stall_en  = eng_reg.stat[STALL_EN_BIT];
    // Pop only while receiving and no RAM write is still on the port
    assign fifo_pop  = (eng_reg.st == S_RX) && !eng_reg.ram_wr;
    assign token_ready = eng_reg.st == S_IDLE;
    // Outputs straight from the state flops
    assign tx_valid           = eng_reg.tx_valid;
    assign tx_data            = eng_reg.tx_data;
    assign tx_last            = eng_reg.tx_last;
    assign tx_zero_len        = eng_reg.tx_zero;
    assign hs_valid           = eng_reg.hs_valid;
    assign hs_code            = eng_reg.hs_code;
    assign ram_rd_en          = eng_reg.ram_rd;
    assign ram_wr_en          = eng_reg.ram_wr;
    assign ram_addr           = eng_reg.ram_addr;
    assign ram_wdata          = eng_reg.ram_wdata;
    assign endpoint_stall_set = eng_reg.stall_set;
    assign endpoint_stall_bd  = eng_reg.bd;
    assign stall_irq          = eng_reg.stall_set;
    assign transfer_done_flag = eng_reg.done;
    assign transfer_status    = eng_reg.status;
    // Next-state logic
    always_comb begin
        eng_next           = eng_reg;
        eng_next.hs_valid  = 1'b0;
        eng_next.ram_rd    = 1'b0;
        eng_next.ram_wr    = 1'b0;
        eng_next.stall_set = 1'b0;
        eng_next.done      = 1'b0;
        unique case (eng_reg.st)
            S_IDLE: begin
                if (token_valid) begin
                    eng_next.pid      = token.pid;
                    eng_next.bd       = token.bd;
                    eng_next.step     = 3'h0;
                    eng_next.ram_rd   = 1'b1;
                    eng_next.ram_addr = BD_BASE_ADDR + {3'h0, token.bd, BD_OFS_STATUS};
                    eng_next.st       = S_FETCH;
                end
            end
            S_FETCH: begin
                // RAM answers one cycle after the read, so capture trails issue
                eng_next.step = eng_reg.step + 3'h1;
                unique case (eng_reg.step)
                    3'h0: begin
                        eng_next.ram_rd   = 1'b1;
                        eng_next.ram_addr = bd_addr + {9'h0, BD_OFS_COUNT};
                    end
                    3'h1: begin
                        eng_next.stat     = ram_rdata;
                        eng_next.ram_rd   = 1'b1;
                        eng_next.ram_addr = bd_addr + {9'h0, BD_OFS_ADR_LO};
                    end
                    3'h2: begin
                        eng_next.cnt_lo   = ram_rdata;
                        eng_next.ram_rd   = 1'b1;
                        eng_next.ram_addr = bd_addr + {9'h0, BD_OFS_ADR_HI};
                    end
                    3'h3: eng_next.adr[7:0] = ram_rdata;
                    default: begin
                        eng_next.adr[15:8] = ram_rdata;
                        eng_next.st        = S_DECIDE;
                    end
                endcase
            end
            S_DECIDE: begin
                eng_next.idx     = '0;
                eng_next.over    = 1'b0;
                eng_next.tog_bad = 1'b0;
                eng_next.err     = 1'b0;
                if (!eng_reg.stat[OWNER_BIT]) begin
                    // Core still owns it: touch nothing
                    eng_next.hs_valid = 1'b1;
                    eng_next.hs_code  = UBD_HS_NAK;
                    eng_next.st       = S_IDLE;
                end else if (stall_en && eng_reg.pid != PID_SETUP) begin
                    // Descriptor left as is, owner flag stays set
                    eng_next.hs_valid  = 1'b1;
                    eng_next.hs_code   = UBD_HS_STALL;
                    eng_next.stall_set = 1'b1;
                    eng_next.st        = S_IDLE;
                end else if (eng_reg.pid == PID_IN) begin
                    eng_next.st = S_TX_RD;
                end else begin
                    eng_next.st = S_RX;
                end
            end
            S_TX_RD: begin
                if (max_cnt == '0) begin
                    eng_next.tx_valid = 1'b1;
                    eng_next.tx_last  = 1'b1;
                    eng_next.tx_zero  = 1'b1;
                    eng_next.st       = S_TX_SEND;
                end else begin
                    eng_next.ram_rd   = 1'b1;
                    eng_next.ram_addr = eng_reg.adr[10:0] + {1'b0, eng_reg.idx};
                    eng_next.st       = S_TX_WAIT;
                end
            end
            S_TX_WAIT: eng_next.st = S_TX_CAP;
            S_TX_CAP: begin
                eng_next.tx_valid = 1'b1;
                eng_next.tx_data  = ram_rdata;
                eng_next.tx_last  = (eng_reg.idx + 10'h1) == max_cnt;
                eng_next.tx_zero  = 1'b0;
                eng_next.st       = S_TX_SEND;
            end
            S_TX_SEND: begin
                if (tx_ready) begin
                    eng_next.tx_valid = 1'b0;
                    eng_next.tx_last  = 1'b0;
                    eng_next.tx_zero  = 1'b0;
                    if (eng_reg.tx_zero) begin
                        eng_next.st = S_WB_CNT;
                    end else begin
                        eng_next.idx = eng_reg.idx + 10'h1;
                        eng_next.st  = eng_reg.tx_last ? S_WB_CNT : S_TX_RD;
                    end
                end
            end
            S_RX: begin
                if (fifo_pop && fifo_valid) begin
                    if (fifo_word.err) begin
                        eng_next.err = 1'b1;
                    end
                    // Expected toggle only matters with checking on
                    if (tog_check && fifo_word.toggle != eng_reg.stat[TOGGLE_BIT]) begin
                        eng_next.tog_bad = 1'b1;
                    end
                    if (!fifo_word.nodata) begin
                        if (eng_reg.idx == max_cnt) begin
                            eng_next.over = 1'b1;
                        end else begin
                            eng_next.idx = eng_reg.idx + 10'h1;
                            // Bad toggle data never lands in the buffer
                            if (!eng_next.tog_bad) begin
                                eng_next.ram_wr    = 1'b1;
                                eng_next.ram_addr  = eng_reg.adr[10:0] + {1'b0, eng_reg.idx};
                                eng_next.ram_wdata = fifo_word.data;
                            end
                        end
                    end
                    if (fifo_word.last) begin
                        eng_next.hs_valid = 1'b1;
                        if (eng_next.err || eng_next.over) begin
                            eng_next.hs_code = UBD_HS_NAK;
                            eng_next.st      = S_IDLE;
                        end else if (eng_next.tog_bad) begin
                            eng_next.hs_code = UBD_HS_ACK;
                            eng_next.st      = S_IDLE;
                        end else begin
                            eng_next.hs_code = UBD_HS_ACK;
                            eng_next.st      = S_WB_CNT;
                        end
                    end
                end
            end
            S_WB_CNT: begin
                // Count goes out before the owner flag is released
                eng_next.ram_wr    = 1'b1;
                eng_next.ram_addr  = bd_addr + {9'h0, BD_OFS_COUNT};
                eng_next.ram_wdata = eng_reg.idx[7:0];
                eng_next.st        = S_WB_STAT;
            end
            S_WB_STAT: begin
                // Status byte last; bit 6 rewritten with the value read back
                eng_next.ram_wr   = 1'b1;
                eng_next.ram_addr = bd_addr + {9'h0, BD_OFS_STATUS};
                eng_next.ram_wdata[OWNER_BIT]  = keep_ownership;
                eng_next.ram_wdata[TOGGLE_BIT] = eng_reg.stat[TOGGLE_BIT];
                eng_next.ram_wdata[PID_LSB+3:PID_LSB] = eng_reg.pid;
                eng_next.ram_wdata[CNT_HI_LSB+1:CNT_HI_LSB] = eng_reg.idx[9:8];
                eng_next.st       = S_FINISH;
            end
            S_FINISH: begin
                eng_next.done         = 1'b1;
                eng_next.status.bd    = eng_reg.bd;
                eng_next.status.pid   = eng_reg.pid;
                eng_next.status.count = eng_reg.idx;
                eng_next.st           = S_IDLE;
            end
            default: eng_next.st = S_IDLE;
        endcase
    end
    // State register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            eng_reg         <= '0;
            eng_reg.st      <= S_IDLE;
            eng_reg.hs_code <= UBD_HS_ACK;
        end else begin
            eng_reg <= eng_next;
        end
    end
endmodule : ubd_engine
`default_nettype wire

/* tb/ubd_checker.sv */
// Concurrent checks on the descriptor engine ports
`timescale 1ns/100ps
`default_nettype none
module ubd_checker
    import ubd_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               srst,
    input wire logic               token_valid,
    input wire ubd_pkg::ubd_token_s token,
    input wire logic               token_ready,
    input wire logic               hs_valid,
    input wire ubd_pkg::ubd_hs_e   hs_code,
    input wire logic               ram_rd_en,
    input wire logic               ram_wr_en,
    input wire logic [10:0]        ram_addr,
    input wire logic [7:0]         ram_wdata,
    input wire logic               endpoint_stall_set,
    input wire logic               stall_irq,
    input wire logic               transfer_done_flag,
    input wire ubd_pkg::ubd_done_s transfer_status
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ======
    // Handshake and token steps
    sequence s_stall; hs_valid && hs_code == UBD_HS_STALL; endsequence
    sequence s_nak; hs_valid && hs_code == UBD_HS_NAK; endsequence
    sequence s_take; token_valid && token_ready; endsequence
    // ======
    // Write-back is checked backwards from the done pulse, since buffer writes share offsets
    AST_STALL_FLAGS: assert property (s_stall |-> endpoint_stall_set && stall_irq)
        else $error("stall handshake without stall flags");
    AST_FLAGS_NEED_STALL: assert property (endpoint_stall_set || stall_irq |-> s_stall)
        else $error("stall flags without stall handshake");
    AST_STALL_FROZEN: assert property (s_stall |=> (!ram_wr_en && !transfer_done_flag) [*4])
        else $error("stalled descriptor was written");
    AST_NAK_NO_DONE: assert property (s_nak |=> !transfer_done_flag [*4])
        else $error("done after a refused packet");
    AST_FIRST_READ: assert property (s_take |=> ram_rd_en
        && ram_addr == BD_BASE_ADDR + {3'h0, $past(token.bd), 2'b00})
        else $error("descriptor fetch at wrong address");
    AST_WB_ORDER: assert property (transfer_done_flag |-> $past(ram_wr_en)
        && $past(ram_wr_en, 2) && $past(ram_addr[1:0]) == BD_OFS_STATUS
        && $past(ram_addr[1:0], 2) == BD_OFS_COUNT)
        else $error("done without count then status write");
    AST_WB_STATUS: assert property (transfer_done_flag |->
        $past(ram_wdata[5:2]) == transfer_status.pid
        && $past(ram_wdata[1:0]) == transfer_status.count[9:8])
        else $error("status byte disagrees with reported pid or count");
    AST_WB_COUNT: assert property (transfer_done_flag |->
        $past(ram_wdata, 2) == transfer_status.count[7:0])
        else $error("count byte disagrees with reported count");
endmodule : ubd_checker
bind ubd_engine ubd_checker i_ubd_checker (.core_clk, .srst, .token_valid, .token,
    .token_ready, .hs_valid, .hs_code, .ram_rd_en, .ram_wr_en, .ram_addr, .ram_wdata,
    .endpoint_stall_set, .stall_irq, .transfer_done_flag, .transfer_status);
`default_nettype wire

/* tb/ubd_host_model.sv */
// Behavioural USB host: tokens, OUT packets and a pacing IN consumer
`timescale 1ns/100ps
`default_nettype none
module ubd_host_model
    import ubd_pkg::*;
(
    input  wire logic             core_clk,
    output logic                  token_valid,
    output ubd_pkg::ubd_token_s   token,
    input  wire logic             token_ready,
    output logic                  rx_valid,
    output ubd_pkg::ubd_rx_word_s rx_word,
    input  wire logic             rx_ready,
    output logic                  tx_ready
);
    logic [7:0] pkt [0:63];
    // Bench marks every packet word bad; stuck records an expired wait
    logic       corrupt = 1'b0;
    logic       stuck = 1'b0;
    // ======
    // Idle outputs at time zero
    initial begin
        token_valid = 1'b0;
        token = '0;
        rx_valid = 1'b0;
        rx_word = '0;
    end
    // Consumer stalls about one beat in four, so IN pacing is exercised
    always @(posedge core_clk) tx_ready <= ($urandom % 4) != 0;
    // Hold a request until the edge that samples ready high, bounded
    task automatic wait_rdy(input logic rx);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (!(rx ? rx_ready : token_ready) && k < 2000);
        if (k >= 2000) stuck = 1'b1;
    endtask : wait_rdy
    // Released lines show inverted data, never a stale copy
    task automatic send_token(input logic [3:0] pid, input logic [5:0] bd);
        token_valid <= 1'b1;
        token <= '{pid: pid, bd: bd};
        wait_rdy(1'b0);
        token_valid <= 1'b0;
        token <= ubd_token_s'(~token);
    endtask : send_token
    // Zero-length packet is one word flagged as carrying no data
    task automatic send_pkt(input int n, input logic tog);
        for (int i = 0; i < ((n == 0) ? 1 : n); i++) begin
            rx_valid <= 1'b1;
            rx_word <= '{corrupt, n == 0, tog, i >= n - 1, pkt[i]};
            wait_rdy(1'b1);
        end
        rx_valid <= 1'b0;
        rx_word <= ubd_rx_word_s'(~rx_word);
    endtask : send_pkt
endmodule : ubd_host_model
`default_nettype wire

/* tb/usb_buffer_descriptor_status_bench.sv */
// Self-checking bench: RAM model, expected descriptor image, scenario list
`timescale 1ns/100ps
`default_nettype none
module usb_buffer_descriptor_status_bench;
    import ubd_pkg::*;
    logic core_clk, srst, keep_ownership, token_valid, token_ready, rx_valid, rx_ready;
    logic tx_valid, tx_last, tx_zero_len, tx_ready, hs_valid, ram_rd_en, ram_wr_en;
    logic endpoint_stall_set, stall_irq, transfer_done_flag, t;
    logic [7:0] tx_data, ram_wdata, ram_rdata, mem [0:2047], exp_mem [0:2047], tx_q [$];
    logic [10:0] ram_addr;
    logic [5:0] endpoint_stall_bd;
    logic [1:0] hs_q [$];
    ubd_token_s token;
    ubd_rx_word_s rx_word;
    ubd_hs_e hs_code;
    ubd_done_s transfer_status;
    int n_fail, checks, n_done, n_full, n, n_zero, last_at;
    // ======
    // Design and far-side host
    ubd_engine i_ubd_engine (.core_clk, .srst, .keep_ownership, .token_valid, .token,
        .token_ready, .rx_valid, .rx_word, .rx_ready, .tx_valid, .tx_data, .tx_last,
        .tx_zero_len, .tx_ready, .hs_valid, .hs_code, .ram_rd_en, .ram_wr_en, .ram_addr,
        .ram_wdata, .ram_rdata, .endpoint_stall_set, .endpoint_stall_bd, .stall_irq,
        .transfer_done_flag, .transfer_status);
    ubd_host_model i_ubd_host_model (.core_clk, .token_valid, .token, .token_ready,
        .rx_valid, .rx_word, .rx_ready, .tx_ready);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Shared RAM with one-cycle read latency, plus result capture
    always @(posedge core_clk) begin
        if (ram_rd_en) ram_rdata <= mem[ram_addr];
        if (ram_wr_en) mem[ram_addr] <= ram_wdata;
        if (hs_valid) hs_q.push_back(hs_code);
        if (transfer_done_flag) n_done++;
        // Beats taken up to and including the one flagged last
        if (tx_valid && tx_ready && tx_last) last_at = tx_q.size() + int'(!tx_zero_len);
        if (tx_valid && tx_ready && tx_zero_len) n_zero++;
        if (tx_valid && tx_ready && !tx_zero_len) tx_q.push_back(tx_data);
        if (!rx_ready) n_full++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch at %0t: got %0h want %0h", $time, got, want);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // Arm a random descriptor, run the host, compare the upper half of the RAM image
    task automatic txn(input logic [3:0] pid, input logic [3:0] cfg, input int c, input int n,
        input logic tog, input logic keep, input logic [1:0] hs, input int wr, input logic upd);
        logic [5:0] bd;
        logic [10:0] a, b;
        logic [7:0] st;
        int i, k, w;
        bd = 6'($urandom % 64);
        a = BD_BASE_ADDR + {3'h0, bd, 2'b00};
        b = 11'h500 + 11'($urandom % 256);
        st = {cfg[3:2], 2'b00, cfg[1:0], 2'(c >> 8)};
        w = (pid == PID_IN) ? c : n;
        for (i = 0; i < 64; i++) i_ubd_host_model.pkt[i] = 8'($urandom);
        keep_ownership <= keep;
        mem[a + 11'd1] <= 8'(c);
        mem[a + 11'd2] <= b[7:0];
        mem[a + 11'd3] <= {5'h00, b[10:8]};
        @(posedge core_clk);
        mem[a] <= st;
        @(posedge core_clk);
        exp_mem = mem;
        hs_q.delete();
        tx_q.delete();
        n_done = 0;
        n_full = 0;
        n_zero = 0;
        last_at = -1;
        for (i = 0; i < wr; i++) exp_mem[b + 11'(i)] = i_ubd_host_model.pkt[i];
        if (upd) exp_mem[a] = {keep, st[6], pid, 2'(w >> 8)};
        if (upd) exp_mem[a + 11'd1] = 8'(w);
        // Long packets arrive before the token so the FIFO fills and refuses
        if (pid == PID_IN) i_ubd_host_model.send_token(pid, bd);
        else if (n > 32) fork
            i_ubd_host_model.send_pkt(n, tog);
            begin
                repeat (40) @(posedge core_clk);
                i_ubd_host_model.send_token(pid, bd);
            end
        join
        else fork
            i_ubd_host_model.send_token(pid, bd);
            i_ubd_host_model.send_pkt(n, tog);
        join
        k = 0;
        while (!(token_ready && (hs_q.size() + n_done) > 0) && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 3000) n_fail++;
        if (k >= 3000) end_of_test();
        repeat (4) @(posedge core_clk);
        chk(hs_q.size(), hs != 2'h3);
        if (hs != 2'h3) chk(hs_q[0], hs);
        chk(n_done, upd);
        if (upd) chk(transfer_status, {bd, pid, 10'(w)});
        if (hs == UBD_HS_STALL) chk(endpoint_stall_bd, bd);
        if (pid == PID_IN && upd) chk(tx_q.size(), c);
        if (pid == PID_IN && upd) chk(last_at, c);
        chk(n_zero, pid == PID_IN && upd && c == 0);
        chk(i_ubd_host_model.stuck, 1'b0);
        for (i = 0; i < tx_q.size(); i++) chk(tx_q[i], mem[b + 11'(i)]);
        for (i = 1024; i < 2048; i++) chk(mem[i], exp_mem[i]);
    endtask : txn
    // Reset, then the scenario list
    initial begin
        srst = 1'b1;
        keep_ownership = 1'b0;
        void'($urandom(54917));
        for (int i = 0; i < 2048; i++) mem[i] <= 8'($urandom);
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        for (int j = 0; j < 4; j++) begin
            t = 1'($urandom);
            n = $urandom % 10;
            txn(PID_OUT, {1'b1, ~t, 2'b00}, 64, n, t, 1'b0, UBD_HS_ACK, n, 1'b1);
        end
        txn(PID_OUT, {1'b1, t, 2'b10}, 8, 8, t, 1'b1, UBD_HS_ACK, 8, 1'b1);
        txn(PID_OUT, {1'b1, ~t, 2'b10}, 8, 8, t, 1'b0, UBD_HS_ACK, 0, 1'b0);
        txn(PID_OUT, 4'h8, 5, 6, t, 1'b0, UBD_HS_NAK, 5, 1'b0);
        // Packet error: refused, descriptor left as armed
        i_ubd_host_model.corrupt = 1'b1;
        txn(PID_OUT, 4'h8, 8, 4, t, 1'b0, UBD_HS_NAK, 4, 1'b0);
        i_ubd_host_model.corrupt = 1'b0;
        txn(PID_IN, 4'h0, 4, 0, t, 1'b0, UBD_HS_NAK, 0, 1'b0);
        txn(PID_IN, 4'h9, 4, 0, t, 1'b0, UBD_HS_STALL, 0, 1'b0);
        txn(PID_SETUP, 4'h9, 8, 8, t, 1'b0, UBD_HS_ACK, 8, 1'b1);
        txn(PID_IN, 4'h8, 257, 0, t, 1'b0, 2'h3, 0, 1'b1);
        txn(PID_IN, 4'h8, 0, 0, t, 1'b1, 2'h3, 0, 1'b1);
        txn(PID_OUT, 4'h8, 64, 40, t, 1'b0, UBD_HS_ACK, 40, 1'b1);
        chk(n_full > 0, 1);
        end_of_test();
    end
endmodule : usb_buffer_descriptor_status_bench
`default_nettype wire
